// File: logic/pss_pkg.sv
// package for the parameter set sequencer: constants and carrier types
// Notes on behaviour
// - A recall command while the sequencer is off copies the stored set chosen by the set pointer into the active parameters.
// - In automatic mode sets advance on frame triggers in ascending index order with no outside action.
// - Each trigger in the PSS_RUN state compares the uses of the current set with its repeat count and reuses or advances.
// - After the last set of the cycle is used up, the next trigger starts over with set 0.
// - A cycle holds exactly the programmed number of sets, at most 64.
// - Enabling the sequencer loads set 0 into the active parameters at once.
// - The first trigger after enabling acquires with set 0.
// - Disabling during a frame lets that frame finish before cycling stops.
// - Disabling restores the active parameters held just before enabling.
// - The repeat count per set accepts 1 to 256.
// - The set pointer addresses sets 0 to 63.
// - A save command while the sequencer is off copies the active parameters into the selected stored set.
package pss_pkg;
  localparam int PSS_NUM_SETS = 64;
  localparam int PSS_IDX_W = 6;
  localparam int PSS_PARAM_W = 32;
  localparam int PSS_RPT_W = 9;
  localparam logic [PSS_IDX_W-1:0] PSS_FIRST_SET = 6'h00;
  localparam logic [PSS_RPT_W-1:0] PSS_RPT_MIN = 9'h001;
  localparam logic [PSS_RPT_W-1:0] PSS_RPT_MAX = 9'h100;
  localparam logic [PSS_IDX_W:0] PSS_TOTAL_MAX = 7'h40;
  localparam logic [PSS_IDX_W:0] PSS_TOTAL_MIN = 7'h01;

  // one stored set: sequence parameters plus its repeat count
  typedef struct packed {
    logic [PSS_PARAM_W-1:0] params;
    logic [PSS_RPT_W-1:0] repeat_count;
  } pss_set_t;

  typedef enum logic [2:0] {
    PSS_OFF = 3'h1,
    PSS_RUN = 3'h2,
    PSS_DRAIN = 3'h4
  } pss_state_t;
endpackage : pss_pkg

// File: logic/pss_store.sv
// storage array of sequence sets with save and read port
`timescale 1ns/1ps
`default_nettype none
module pss_store #(
  parameter int DEPTH = 64
) (
  // clock
  input wire logic CLK,
  // write side
  input wire logic wr_en,
  input wire logic [pss_pkg::PSS_IDX_W-1:0] wr_idx,
  input wire pss_pkg::pss_set_t wr_data,
  // read side, combinational
  input wire logic [pss_pkg::PSS_IDX_W-1:0] rd_idx,
  output var pss_pkg::pss_set_t rd_data
);
  import pss_pkg::*;
  if (DEPTH < 1 || DEPTH > PSS_NUM_SETS) begin : g_bad_depth
    $error("pss_store: DEPTH out of range");
  end
  // volatile only: contents are undefined until software saves them
  pss_set_t mem [DEPTH];
  always_ff @(posedge CLK) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end
  assign rd_data = mem[rd_idx];
endmodule // pss_store
`default_nettype wire

// File: logic/pss_sequencer.sv
// parameter set sequencer top: auto advance, enable/disable, save and recall
`timescale 1ns/1ps
`default_nettype none
module pss_sequencer #(
  parameter int NUM_SETS = 64
) (
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // software settings and commands
  input wire logic SEQ_ENABLE,
  input wire logic [pss_pkg::PSS_IDX_W:0] TOTAL_SETS,
  input wire logic [pss_pkg::PSS_IDX_W-1:0] SET_POINTER_VALUE,
  input wire logic [pss_pkg::PSS_RPT_W-1:0] REPEAT_COUNT,
  input wire logic SAVE_SET_CMD,
  input wire logic RECALL_SET_CMD,
  input wire logic [pss_pkg::PSS_PARAM_W-1:0] SW_PARAMS,
  input wire logic SW_PARAMS_WR,
  // frame timing
  input wire logic FRAME_TRIGGER,
  input wire logic FRAME_BUSY,
  // status and active configuration
  output logic [pss_pkg::PSS_PARAM_W-1:0] ACTIVE_PARAMS,
  output logic [pss_pkg::PSS_IDX_W-1:0] CURRENT_SET,
  output logic SEQ_RUNNING,
  output logic SETTING_ERROR
);
  import pss_pkg::*;

  // pointer and cycle length are sized for at most the full set count
  if (NUM_SETS < 1 || NUM_SETS > PSS_NUM_SETS) begin : g_bad_sets
    $error("pss_sequencer: NUM_SETS out of range");
  end

  function automatic logic [PSS_IDX_W-1:0] wrap_next(
      input logic [PSS_IDX_W-1:0] idx, input logic [PSS_IDX_W:0] total);
    logic [PSS_IDX_W:0] nxt;
    nxt = {1'b0, idx} + 7'h01;
    wrap_next = (nxt >= total) ? PSS_FIRST_SET : nxt[PSS_IDX_W-1:0];
  endfunction

  pss_state_t state, next_state;
  logic [PSS_PARAM_W-1:0] active, next_active;
  logic [PSS_PARAM_W-1:0] saved, next_saved;
  logic [PSS_IDX_W-1:0] cur, next_cur;
  logic [PSS_RPT_W-1:0] uses, next_uses;
  logic running, next_running;
  logic err, next_err;
  logic [PSS_IDX_W-1:0] rd_idx;
  pss_set_t rd_set, wr_set, cur_set;
  logic total_ok, rpt_ok, ptr_ok, wr_en;

  assign total_ok = TOTAL_SETS >= PSS_TOTAL_MIN && TOTAL_SETS <= PSS_TOTAL_MAX
    && TOTAL_SETS <= 7'(NUM_SETS);
  assign rpt_ok = REPEAT_COUNT >= PSS_RPT_MIN
    && REPEAT_COUNT <= PSS_RPT_MAX;
  assign ptr_ok = 32'(SET_POINTER_VALUE) < NUM_SETS;

  // save only while off so stored sets stay coherent with a running cycle
  assign wr_en = SAVE_SET_CMD && rpt_ok && ptr_ok && state == PSS_OFF;
  assign wr_set = '{params: active, repeat_count: REPEAT_COUNT};

  // read address: next set on advance, set 0 on enable, current set while running, pointer when off
  always_comb begin
    rd_idx = SET_POINTER_VALUE;
    if (state == PSS_OFF && SEQ_ENABLE) begin
      rd_idx = PSS_FIRST_SET;
    end else if (state != PSS_OFF) begin
      rd_idx = cur;
      if (FRAME_TRIGGER) begin
        if (uses >= cur_set.repeat_count) rd_idx = wrap_next(cur, TOTAL_SETS);
      end
    end
  end

  pss_store #(.DEPTH(NUM_SETS)) u_store (
    .CLK(CLK),
    .wr_en(wr_en),
    .wr_idx(SET_POINTER_VALUE),
    .wr_data(wr_set),
    .rd_idx(rd_idx),
    .rd_data(rd_set)
  );
  // mirror copy: a second read port for the repeat count of the current set
  pss_store #(.DEPTH(NUM_SETS)) u_shadow (
    .CLK(CLK),
    .wr_en(wr_en),
    .wr_idx(SET_POINTER_VALUE),
    .wr_data(wr_set),
    .rd_idx(cur),
    .rd_data(cur_set)
  );

  always_comb begin
    next_state = state;
    next_active = active;
    next_saved = saved;
    next_cur = cur;
    next_uses = uses;
    next_running = running;
    next_err = err;
    case (state)
      PSS_OFF: begin
        next_running = 1'b0;
        if (SEQ_ENABLE) begin
          next_err = !total_ok;
          if (total_ok) begin
            next_saved = active; // kept for restore
            next_active = rd_set.params;
            next_cur = PSS_FIRST_SET;
            next_uses = '0;
            next_running = 1'b1;
            next_state = PSS_RUN;
          end
        end else if (RECALL_SET_CMD && ptr_ok) begin
          next_active = rd_set.params;
          next_cur = SET_POINTER_VALUE;
        end else if (SW_PARAMS_WR) begin
          next_active = SW_PARAMS;
        end
      end
      PSS_RUN, PSS_DRAIN: begin
        if (FRAME_TRIGGER && state == PSS_RUN) begin
          if (uses >= cur_set.repeat_count) begin
            next_cur = rd_idx;
            next_active = rd_set.params;
            next_uses = 9'h001;
          end else begin
            next_uses = uses + 9'h001;
          end
        end
        if (!SEQ_ENABLE || state == PSS_DRAIN) begin
          next_state = PSS_DRAIN;
          if (!FRAME_BUSY && !FRAME_TRIGGER) begin
            next_active = saved;
            next_running = 1'b0;
            next_uses = '0;
            next_state = PSS_OFF;
          end
        end
      end
      default: begin
        next_state = PSS_OFF;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state <= PSS_OFF;
      active <= '0;
      saved <= '0;
      cur <= PSS_FIRST_SET;
      uses <= '0;
      running <= 1'b0;
      err <= 1'b0;
    end else begin
      state <= next_state;
      active <= next_active;
      saved <= next_saved;
      cur <= next_cur;
      uses <= next_uses;
      running <= next_running;
      err <= next_err;
    end
  end

  assign ACTIVE_PARAMS = active;
  assign CURRENT_SET = cur;
  assign SEQ_RUNNING = running;
  assign SETTING_ERROR = err;

  a_off_stable: assert property (@(posedge CLK)
    disable iff (SYS_RST) state == PSS_OFF && !SEQ_ENABLE
    && !RECALL_SET_CMD && !SW_PARAMS_WR |=> $stable(active))
    else $error("active changed while off");
  a_enable_set0: assert property (@(posedge CLK)
    disable iff (SYS_RST) state == PSS_OFF && SEQ_ENABLE && total_ok
    |=> cur == PSS_FIRST_SET && uses == '0 && running)
    else $error("enable did not load set 0");
  a_first_trig: assert property (@(posedge CLK)
    disable iff (SYS_RST) state == PSS_RUN && uses == '0 && FRAME_TRIGGER
    |=> $stable(cur) && uses == 9'h001)
    else $error("first trigger not on set 0");
  a_reuse_set: assert property (@(posedge CLK)
    disable iff (SYS_RST) state == PSS_RUN && FRAME_TRIGGER
    && uses < cur_set.repeat_count |=> $stable(cur))
    else $error("set left early");
  a_advance_set: assert property (@(posedge CLK)
    disable iff (SYS_RST) state == PSS_RUN && FRAME_TRIGGER
    && uses >= cur_set.repeat_count && uses != '0
    |=> uses == 9'h001 && cur == wrap_next($past(cur), $past(TOTAL_SETS)))
    else $error("bad advance");
  a_wrap_zero: assert property (@(posedge CLK)
    disable iff (SYS_RST) state == PSS_RUN && FRAME_TRIGGER
    && uses >= cur_set.repeat_count && {1'b0, cur} == TOTAL_SETS - 7'h01
    |=> cur == PSS_FIRST_SET) else $error("no wrap to set 0");
  a_busy_hold: assert property (@(posedge CLK)
    disable iff (SYS_RST) state == PSS_DRAIN && FRAME_BUSY
    |=> state != PSS_OFF) else $error("stopped mid frame");
  a_restore: assert property (@(posedge CLK)
    disable iff (SYS_RST) state != PSS_OFF ##1 state == PSS_OFF
    |-> active == $past(saved)) else $error("params not restored");
  a_recall: assert property (@(posedge CLK)
    disable iff (SYS_RST) state == PSS_OFF && !SEQ_ENABLE
    && RECALL_SET_CMD && ptr_ok |=> active == $past(rd_set.params))
    else $error("recall lost");
  a_cur_range: assert property (@(posedge CLK)
    disable iff (SYS_RST) running |-> {1'b0, cur} < TOTAL_SETS || !total_ok)
    else $error("set outside cycle");
  // a trigger that lands after disable must not start another set
  a_drain_trig: assert property (@(posedge CLK)
    disable iff (SYS_RST) state == PSS_DRAIN && FRAME_TRIGGER
    |=> $stable(cur) && $stable(uses) && $stable(active))
    else $error("trigger used in drain");

  c_enable: cover property (@(posedge CLK) state == PSS_OFF ##1
    state == PSS_RUN);
  c_wrap: cover property (@(posedge CLK) state == PSS_RUN && cur != '0
    ##1 cur == '0 && state == PSS_RUN);
  c_drain: cover property (@(posedge CLK) state == PSS_DRAIN && FRAME_BUSY
    ##1 state == PSS_DRAIN);
  c_recall: cover property (@(posedge CLK) state == PSS_OFF
    && RECALL_SET_CMD);
  c_reuse: cover property (@(posedge CLK) state == PSS_RUN && FRAME_TRIGGER
    && uses != '0 && uses < cur_set.repeat_count);
endmodule // pss_sequencer
`default_nettype wire

// File: test/pss_frame_src.sv
// frame source model: one trigger pulse and a busy window per request
`timescale 1ns/1ps
`default_nettype none
module pss_frame_src #(
  parameter int BUSY_LEN = 3
) (
  // clock and request
  input wire logic CLK,
  input wire logic start,
  // frame timing
  output logic trig,
  output logic busy
);
  int cnt = 0;
  always_ff @(posedge CLK) begin
    trig <= start;
    cnt <= start ? BUSY_LEN : (cnt > 0 ? cnt - 1 : 0);
  end
  // busy rises with its trigger and stays high for BUSY_LEN cycles
  assign busy = cnt > 0;
endmodule // pss_frame_src
`default_nettype wire

// File: test/pss_sequencer_bench.sv
// self-checking bench for the parameter set sequencer
`timescale 1ns/1ps
`default_nettype none
module pss_sequencer_bench;
  import pss_pkg::*;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, sv = 1'b0, rc = 1'b0;
  logic pw = 1'b0, go = 1'b0, trig, busy, run, serr;
  logic [6:0] tot = 7'h06;
  logic [5:0] ptr = 6'h00, cur;
  logic [8:0] rpt = 9'h001;
  logic [31:0] swp = 32'h0, act;
  logic [31:0] par [64];
  logic [8:0] rp [64];
  int err_total = 0, tests_run = 0, cyc = 0;

  pss_sequencer u_pss_sequencer (.CLK(clk), .SYS_RST(rst),
    .SEQ_ENABLE(en), .TOTAL_SETS(tot), .SET_POINTER_VALUE(ptr),
    .REPEAT_COUNT(rpt), .SAVE_SET_CMD(sv), .RECALL_SET_CMD(rc),
    .SW_PARAMS(swp), .SW_PARAMS_WR(pw), .FRAME_TRIGGER(trig),
    .FRAME_BUSY(busy), .ACTIVE_PARAMS(act), .CURRENT_SET(cur),
    .SEQ_RUNNING(run), .SETTING_ERROR(serr));
  pss_frame_src u_pss_frame_src (.CLK(clk), .start(go), .trig(trig),
    .busy(busy));

  initial forever #20 clk = ~clk;
  // about 1550 cycles needed, so this leaves ample margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      end_of_test();
    end
  end

  task stp(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk_v(logic [31:0] g, logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task chk_b(logic g, logic e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task frame;
    go = 1'b1;
    stp();
    go = 1'b0;
    for (int i = 0; i < 20 && (busy !== 1'b0 || trig !== 1'b0); i++) stp();
  endtask
  task store(int i, logic [31:0] p, logic [8:0] r);
    swp = p;
    pw = 1'b1;
    stp();
    pw = 1'b0;
    ptr = i[5:0];
    rpt = r;
    sv = 1'b1;
    stp();
    sv = 1'b0;
    par[i] = p;
    rp[i] = r;
  endtask
  task recall(int i);
    ptr = i[5:0];
    stp();
    rc = 1'b1; // sequencer is off here
    stp();
    rc = 1'b0;
    stp();
    chk_v(act, par[i]);
    chk_v(cur, i);
    $display("done recall");
  endtask
  task t_auto(logic [6:0] t, int n);
    logic [31:0] base;
    int c, u;
    base = 32'h0BA5E000 + n;
    swp = base;
    pw = 1'b1;
    stp();
    pw = 1'b0;
    tot = t;
    en = 1'b1;
    stp();
    chk_v(act, par[0]);
    chk_b(run, 1'b1);
    chk_b(serr, 1'b0);
    c = 0;
    u = 0;
    for (int k = 0; k < n + 1; k++) begin
      if (k == n) begin
        go = 1'b1;
        stp();
        go = 1'b0;
        stp();
        en = 1'b0;
      end else
        frame();
      if (u < rp[c]) u++;
      else begin
        c = (c + 1) % t;
        u = 1;
      end
      chk_v(cur, c);
      chk_v(act, par[c]);
    end
    stp();
    chk_b(run, 1'b1);
    chk_v(act, par[c]);
    // a trigger during the drain must leave set and parameters alone
    go = 1'b1;
    stp();
    go = 1'b0;
    stp();
    chk_v(act, par[c]);
    chk_v(cur, c);
    for (int i = 0; i < 20 && busy !== 1'b0; i++) stp();
    stp();
    chk_b(run, 1'b0);
    chk_v(act, base);
    frame();
    chk_v(act, base);
    $display("done auto");
  endtask
  task t_bad(logic [6:0] t);
    tot = t;
    en = 1'b1;
    stp();
    chk_b(serr, 1'b1);
    chk_b(run, 1'b0);
    en = 1'b0;
    stp();
    $display("done bad total");
  endtask
  task end_of_test;
    $display("checks %0d wrong %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    stp(20);
    rst = 1'b0;
    for (int i = 0; i < 64; i++)
      store(i, 32'h5A000000 + i, (i == 1) ? 9'h003 : (i == 5) ? 9'h002 : 9'h001);
    t_auto(7'h06, 10);
    t_auto(7'h40, 70);
    store(0, 32'h5A000100, 9'h100);
    t_auto(7'h02, 258);
    recall(63);
    recall(2);
    t_bad(7'h00);
    t_bad(7'h41);
    end_of_test();
  end
endmodule // pss_sequencer_bench
`default_nettype wire
